// File: sld_pkg.sv
// sld_pkg: shared constants and types for the serial latched driver
// assumes a 20 MHz system clock and a slower serial link sampled by it
package sld_pkg;
	localparam int unsigned SLD_WIDTH     = 32;
	localparam int unsigned SLD_FIFO_DEPTH = 4;
	localparam int unsigned SLD_CLK_NS    = 50;
	// gap from last clock edge to latch enable, kept by the host
	localparam int unsigned SLD_STROBE_GAP_NS = 300;
	localparam int unsigned SLD_STROBE_GAP_CYC = SLD_STROBE_GAP_NS / SLD_CLK_NS;
	localparam logic [SLD_WIDTH-1:0] SLD_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic sclk;
		logic sdata;
		logic strobe;
		logic blank;
	} sld_pins_t;

	typedef logic [SLD_WIDTH-1:0] sld_word_t;
endpackage

// File: sld_fifo.sv
// sld_fifo: small valid/ready FIFO for shift register snapshots
// assumes one clock, asynchronous active-low reset
`timescale 1ns/10ps
module sld_fifo
	import sld_pkg::*;
#(
	parameter int unsigned WIDTH = SLD_WIDTH,
	parameter int unsigned DEPTH = SLD_FIFO_DEPTH
)
(
	input  wire logic             mclk,
	input  wire logic             arst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_q];

	always_ff @(posedge mclk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// File: sld_driver.sv
// sld_driver: 32-position serial-in shift register, latch array and blanked outputs
// assumes the link pins are asynchronous to mclk and slow against it
// Notes on behaviour
// - a rising serial clock captures the serial data input into the first stage.
// - each rising serial clock moves every stage one place toward the serial output.
// - while latch enable is high each latch takes its shift stage value.
// - latches stay transparent and follow the register while latch enable is high.
// - with blanking high every output is low and its source driver is off.
// - blanking never changes the latch contents.
// - with blanking low each output follows its own latch.
// - register, latches and outputs are each 32 positions wide.
`timescale 1ns/10ps
module sld_driver
	import sld_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      arst_n,
	input  wire sld_pins_t pins,
	output sld_word_t      drv_out,
	output sld_word_t      src_en,
	output logic           sdo,
	output logic           fifo_stall
);
	sld_pins_t meta_q;
	sld_pins_t sync_q;
	logic      sclk_d1_q;
	logic      rise;
	sld_word_t shift_q;
	sld_word_t shift_d;
	sld_word_t latch_q;
	sld_word_t fifo_out;
	logic      fifo_valid;
	logic      fifo_in_ready;
	logic      out_ready;
	logic      sdo_q;

	// two-stage synchroniser for all link pins
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_q    <= '0;
			sync_q    <= '0;
			sclk_d1_q <= 1'b0;
		end
		else
		begin
			meta_q    <= pins;
			sync_q    <= meta_q;
			sclk_d1_q <= sync_q.sclk;
		end
	end

	// host keeps data stable through the edge, so synchronised data is valid here
	assign rise    = sync_q.sclk && !sclk_d1_q;
	assign shift_d = {shift_q[SLD_WIDTH-2:0], sync_q.sdata};

	// shift register, stalls only if the snapshot buffer is full
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			shift_q <= SLD_ZERO;
		else if (rise && fifo_in_ready)
			shift_q <= shift_d;
	end

	assign fifo_stall = !fifo_in_ready;

	// every new register value is buffered on its way to the latches
	sld_fifo #(
		.WIDTH(SLD_WIDTH),
		.DEPTH(SLD_FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.in_valid  (rise),
		.in_ready  (fifo_in_ready),
		.in_data   (shift_d),
		.out_valid (fifo_valid),
		.out_ready (out_ready),
		.out_data  (fifo_out)
	);

	// drain always; only transparent latches take the word
	assign out_ready = 1'b1;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			latch_q <= SLD_ZERO;
		else if (sync_q.strobe)
		begin
			if (fifo_valid)
				latch_q <= fifo_out;
			else
				latch_q <= shift_q;
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			sdo_q <= 1'b0;
		else
			sdo_q <= shift_q[SLD_WIDTH-1];
	end

	assign sdo = sdo_q;

	// output stage: blanking forces low and disables sourcing
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			drv_out <= SLD_ZERO;
			src_en  <= SLD_ZERO;
		end
		else if (sync_q.blank)
		begin
			drv_out <= SLD_ZERO;
			src_en  <= SLD_ZERO;
		end
		else
		begin
			drv_out <= latch_q;
			src_en  <= latch_q;
		end
	end

	property p_blank_low;
		@(posedge mclk) disable iff (!arst_n)
		sync_q.blank |=> (drv_out == SLD_ZERO) && (src_en == SLD_ZERO);
	endproperty
	AST_BLANK_LOW: assert property (p_blank_low)
		else $error("outputs not low under blanking");

	sequence s_edge;
		rise && fifo_in_ready;
	endsequence

	sequence s_still;
		!sync_q.blank && !sync_q.strobe;
	endsequence

	sequence s_open;
		!sync_q.blank;
	endsequence

	sequence s_blanked;
		sync_q.blank;
	endsequence

	sequence s_quiet_strobe;
		(sync_q.strobe && !rise) ##1 sync_q.strobe;
	endsequence

	sequence s_push_then_pop;
		s_edge ##1 fifo_valid;
	endsequence

	AST_FOLLOW_LATCH: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_open |=> drv_out == $past(latch_q))
		else $error("output does not follow latch");

	AST_SRC_FOLLOW: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_open |=> src_en == $past(latch_q))
		else $error("source enable does not follow latch");

	AST_UNBLANK: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$fell(sync_q.blank) |=> drv_out == $past(latch_q))
		else $error("output wrong after unblank");

	AST_BLANK_SRC: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_blanked ##1 s_blanked |-> src_en == SLD_ZERO)
		else $error("source on under blanking");

	AST_HOLD: assert property (
		@(posedge mclk) disable iff (!arst_n)
		!sync_q.strobe |=> $stable(latch_q))
		else $error("latch changed while enable low");

	AST_OUT_STEADY: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_still ##1 s_still |=> $stable(drv_out))
		else $error("output moved with latch closed");

	AST_SRC_STEADY: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_still ##1 s_still |=> $stable(src_en))
		else $error("source enable moved with latch closed");

	AST_RESET_OUT: assert property (
		@(posedge mclk)
		!arst_n ##1 !arst_n |-> ##1 (drv_out == SLD_ZERO) && (latch_q == SLD_ZERO) && !sdo)
		else $error("state not cleared by reset");

	AST_BLANK_KEEPS: assert property (
		@(posedge mclk) disable iff (!arst_n)
		(!sync_q.strobe && $changed(sync_q.blank)) |=> $stable(latch_q))
		else $error("blanking disturbed latch");

	AST_LATCH_BLANKED: assert property (
		@(posedge mclk) disable iff (!arst_n)
		(sync_q.blank && !sync_q.strobe) |=> $stable(latch_q))
		else $error("latch moved while blanked");

	AST_BLANK_TRANSP: assert property (
		@(posedge mclk) disable iff (!arst_n)
		(sync_q.strobe && $changed(sync_q.blank)) |=> latch_q == $past(shift_q))
		else $error("blanking broke transparency");

	AST_SYNC_STAGE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> sync_q == $past(meta_q))
		else $error("synchroniser stage skipped");

	AST_EDGE_ONCE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		rise |=> !rise)
		else $error("edge seen twice");

	AST_CAPTURE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_edge |=> shift_q[0] == $past(sync_q.sdata))
		else $error("first stage missed data");

	AST_D1_TRACK: assert property (
		@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> sclk_d1_q == $past(sync_q.sclk))
		else $error("edge detector lost clock level");

	AST_SHIFT: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_edge |=> shift_q[SLD_WIDTH-1:1] == $past(shift_q[SLD_WIDTH-2:0]))
		else $error("shift did not advance");

	AST_SHIFT_WORD: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_edge |=> shift_q == $past(shift_d))
		else $error("register missed next value");

	AST_NO_EDGE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		!rise |=> $stable(shift_q))
		else $error("register moved without edge");

	AST_NO_STALL: assert property (
		@(posedge mclk) disable iff (!arst_n)
		1'b1 |-> !fifo_stall)
		else $error("snapshot buffer filled up");

	AST_SDO_NEXT: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_edge |-> ##2 sdo == $past(shift_q[SLD_WIDTH-2], 2))
		else $error("serial output did not advance");

	AST_FIFO_FILL: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_edge |=> fifo_valid)
		else $error("buffer missed snapshot");

	AST_FIFO_WORD: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_edge |=> fifo_out == shift_q)
		else $error("buffered word differs from register");

	AST_FIFO_DRAIN: assert property (
		@(posedge mclk) disable iff (!arst_n)
		(fifo_valid && !rise) |=> !fifo_valid)
		else $error("buffer did not drain");

	AST_FIFO_IDLE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		(!fifo_valid && !rise) |=> !fifo_valid)
		else $error("buffer filled without edge");

	AST_FIFO_ONCE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_push_then_pop |=> !fifo_valid)
		else $error("snapshot left in buffer");

	AST_TRANSP: assert property (
		@(posedge mclk) disable iff (!arst_n)
		(sync_q.strobe && !fifo_valid) |=> latch_q == $past(shift_q))
		else $error("latch not transparent");

	AST_TRANSP2: assert property (
		@(posedge mclk) disable iff (!arst_n)
		(sync_q.strobe && fifo_valid) |=> latch_q == $past(fifo_out))
		else $error("latch missed buffered word");

	AST_TRANSP_ANY: assert property (
		@(posedge mclk) disable iff (!arst_n)
		sync_q.strobe |=> latch_q == $past(shift_q))
		else $error("latch lags register");

	AST_SETTLED: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_quiet_strobe |-> latch_q == shift_q)
		else $error("open latch differs from register");

	AST_SDO: assert property (
		@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> sdo == $past(shift_q[SLD_WIDTH-1]))
		else $error("serial output wrong");

	AST_SDO_TRACK: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_edge |-> ##2 sdo == $past(shift_d[SLD_WIDTH-1], 2))
		else $error("serial output missed new last stage");

	AST_SDO_IDLE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		!rise ##1 !rise |=> $stable(sdo))
		else $error("serial output moved without edge");
endmodule

// File: sld_host.sv
// sld_host: behavioural host that drives the serial link pins
// assumes mclk at 20 MHz; link clock period 450 ns, still between frames
`timescale 1ns/10ps
module sld_host
	import sld_pkg::*;
(
	input  wire logic mclk,
	output sld_pins_t pins
);
	initial
	begin
		pins = '{sclk: 1'b0, sdata: 1'b0, strobe: 1'b0, blank: 1'b0};
	end

	// one bit: setup 200 ns before the rise, held 200 ns after it
	task automatic shift_bit(input logic b);
	begin
		pins.sdata <= b;
		repeat (4) @(posedge mclk);
		pins.sclk <= 1'b1;
		repeat (4) @(posedge mclk);
		pins.sclk <= 1'b0;
		pins.sdata <= ~b;
		@(posedge mclk);
	end
	endtask

	// msb first, then the gap before any strobe
	task automatic shift_word(input sld_word_t w);
	begin
		for (int i = SLD_WIDTH - 1; i >= 0; i--)
			shift_bit(w[i]);
		repeat (8) @(posedge mclk);
	end
	endtask

	task automatic set_ctrl(input logic strobe, input logic blank);
	begin
		pins.strobe <= strobe;
		pins.blank  <= blank;
		@(posedge mclk);
	end
	endtask
endmodule

// File: tb.sv
// tb: self-checking bench for the serial latched driver
// assumes sld_host as the link partner; results settle within 12 mclk
`timescale 1ns/10ps
module tb
	import sld_pkg::*;
;
	logic      mclk;
	logic      arst_n;
	sld_pins_t pins;
	sld_word_t drv_out;
	sld_word_t src_en;
	logic      sdo;
	logic      fifo_stall;
	int        err_total = 0;
	int        checks = 0;
	int        cyc = 0;
	localparam sld_word_t WA = 32'ha5c3_0f96;
	localparam sld_word_t WB = 32'h3c5a_e187;

	sld_host u_sld_host (.mclk(mclk), .pins(pins));
	sld_driver u_sld_driver (.mclk(mclk), .arst_n(arst_n), .pins(pins), .drv_out(drv_out),
		.src_en(src_en), .sdo(sdo), .fifo_stall(fifo_stall));

	task automatic check(input string name, input sld_word_t exp, input sld_word_t got);
	begin
		checks++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	end
	endtask

	task automatic conclude;
	begin
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask

	// load a word and move it to the outputs
	task automatic scen_load;
	begin
		check("drv_out after reset", SLD_ZERO, drv_out);
		check("sdo after reset", SLD_ZERO, {31'h0, sdo});
		u_sld_host.shift_word(WA);
		check("sdo", {31'h0, WA[31]}, {31'h0, sdo});
		check("drv_out before strobe", SLD_ZERO, drv_out);
		u_sld_host.set_ctrl(1'b1, 1'b0);
		repeat (4) @(posedge mclk);
		u_sld_host.set_ctrl(1'b0, 1'b0);
		repeat (8) @(posedge mclk);
		check("drv_out", WA, drv_out);
		check("src_en", WA, src_en);
	end
	endtask

	// shifting with strobe low leaves the outputs alone
	task automatic scen_hold;
	begin
		u_sld_host.shift_word(WB);
		check("drv_out held", WA, drv_out);
		check("sdo", {31'h0, WB[31]}, {31'h0, sdo});
		check("fifo_stall", SLD_ZERO, {31'h0, fifo_stall});
	end
	endtask

	// transparent latch shifting one bit while blanked, then unblanked
	task automatic scen_transp;
	begin
		u_sld_host.set_ctrl(1'b0, 1'b1);
		repeat (6) @(posedge mclk);
		check("drv_out blanked", SLD_ZERO, drv_out);
		check("src_en blanked", SLD_ZERO, src_en);
		u_sld_host.set_ctrl(1'b1, 1'b1);
		u_sld_host.shift_bit(1'b1);
		repeat (8) @(posedge mclk);
		check("drv_out blanked", SLD_ZERO, drv_out);
		u_sld_host.set_ctrl(1'b1, 1'b0);
		repeat (8) @(posedge mclk);
		check("drv_out follows", {WB[30:0], 1'b1}, drv_out);
		check("sdo", {31'h0, WB[30]}, {31'h0, sdo});
		u_sld_host.set_ctrl(1'b0, 1'b1);
		u_sld_host.set_ctrl(1'b0, 1'b0);
		repeat (8) @(posedge mclk);
		check("drv_out kept", {WB[30:0], 1'b1}, drv_out);
		check("src_en kept", {WB[30:0], 1'b1}, src_en);
	end
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total++;
			conclude();
		end
	end

	initial
	begin
		arst_n = 1'b0;
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		scen_load();
		scen_hold();
		scen_transp();
		conclude();
	end
endmodule
